//--- common/gtm_cfg.svh
// Register map, field positions, reset values and timing counts of the timer
// Summary of operation
// - First-compare mask picks pins driven on match
// - Masked pins take first-compare data bit
// - Sixteen-bit free-running counter is common time base
// - Accumulator counts only while enable bit set
// - Event mode: edge select picks counted edge
// - Gated mode: pin level inhibits selected clock
// - Bit 15 reads accumulator pin, read only
// - Bit 11 reads external clock pin level
// - Select bit: 0 compare five, 1 capture four
// - Shared register is capture four or compare five
// - Clock code 00: system clock over 512
// - Eight-bit accumulator count is software read/write
// - Capture latches counter on edge, resets all ones
// - Compare matches counter, resets to all ones
// - Codes 01 toggle, 10 low, 11 high
// - Code 00 leaves compare pin unchanged
// - Vector base nibble heads every vector number
// - Edge field: 00 off, rise, fall, any
`ifndef GTM_CFG_SVH
`define GTM_CFG_SVH
// Register offsets
`define GTM_A_ICR     8'h04
`define GTM_A_PORT    8'h06
`define GTM_A_OC1     8'h08
`define GTM_A_CNT     8'h0a
`define GTM_A_ACC     8'h0c
`define GTM_A_CAP1    8'h0e
`define GTM_A_CAP2    8'h10
`define GTM_A_CAP3    8'h12
`define GTM_A_CMP1    8'h14
`define GTM_A_CMP2    8'h16
`define GTM_A_CMP3    8'h18
`define GTM_A_CMP4    8'h1a
`define GTM_A_SHARED  8'h1c
`define GTM_A_TCTL    8'h1e
// Field positions and masks
`define GTM_ICR_MASK  16'h00f0
`define GTM_OC1_MASK  16'hf8f8
`define GTM_ACC_WMASK 8'h77
`define GTM_B_EN      6
`define GTM_B_GATED   5
`define GTM_B_EDGE    4
`define GTM_B_SEL     2
// Reset values
`define GTM_RST_ONES  16'hffff
`define GTM_RST_ZERO  16'h0000
// Timing counts in system clock cycles
`define GTM_DIV_SLOW  512
`define GTM_CNT_DIV   4
`endif

//--- common/gtm_pkg.sv
// Types shared by the timer design
package gtm_pkg;
    // Gated-mode clock sources
    typedef enum logic [1:0] {
        GTM_CLK_DIV512 = 2'b00,
        GTM_CLK_COUNT  = 2'b01,
        GTM_CLK_OVF    = 2'b10,
        GTM_CLK_EXT    = 2'b11
    } gtm_clk_sel_t;
    // Compare pin actions
    typedef enum logic [1:0] {
        GTM_ACT_OFF    = 2'b00,
        GTM_ACT_TOGGLE = 2'b01,
        GTM_ACT_LOW    = 2'b10,
        GTM_ACT_HIGH   = 2'b11
    } gtm_act_t;
    // Capture edge choices
    typedef enum logic [1:0] {
        GTM_EDGE_OFF  = 2'b00,
        GTM_EDGE_RISE = 2'b01,
        GTM_EDGE_FALL = 2'b10,
        GTM_EDGE_ANY  = 2'b11
    } gtm_edge_t;
endpackage

//--- hw/gtm_timer.sv
// Timer with captures, compares and pulse accumulator
`timescale 1ns/1ps
`include "gtm_cfg.svh"
module gtm_timer
    import gtm_pkg::*;
(
    input  wire logic        clk,      // System clock, 125 MHz
    input  wire logic        sys_rst,  // Synchronous reset, high
    input  wire logic [7:0]  addr,     // Register byte offset
    input  wire logic [15:0] wr_data,  // Write data
    input  wire logic        wr_en,    // Write strobe
    input  wire logic        rd_en,    // Read strobe
    output logic      [15:0] rd_data,  // Read data, next cycle
    input  wire logic [3:1]  cap_pin,  // Capture pins one to three
    input  wire logic        ch45_sense, // Shared pin, level seen
    output logic             ch45_drive, // Shared pin, level driven
    output logic             ch45_oe,    // Shared pin drive enable
    input  wire logic        acc_pin,    // Accumulator pin level
    input  wire logic        ext_clk,  // External accumulator clock
    output logic      [4:1]  cmp_pin,  // Compare pins one to four
    output logic      [3:0]  vec_base  // Vector number top nibble
);

    // Capture decision for one edge field
    function automatic logic cap_fire(logic [1:0] code, logic r,
                                      logic f);
        case (gtm_edge_t'(code))
            GTM_EDGE_RISE: cap_fire = r;
            GTM_EDGE_FALL: cap_fire = f;
            GTM_EDGE_ANY:  cap_fire = r | f;
            default:       cap_fire = 1'b0;
        endcase
    endfunction

    // Pin value after a compare match
    function automatic logic act_next(logic cur, logic [1:0] code);
        case (gtm_act_t'(code))
            GTM_ACT_TOGGLE: act_next = ~cur;
            GTM_ACT_LOW:    act_next = 1'b0;
            GTM_ACT_HIGH:   act_next = 1'b1;
            default:        act_next = cur;
        endcase
    endfunction

    // Pin synchronisers and edges
    logic [5:0]  raw;
    logic [5:0]  s1_q;
    logic [5:0]  s2_q;
    logic [5:0]  s3_q;
    logic [5:0]  lvl_q;
    logic [5:0]  prev_q;
    logic [5:0]  rise;
    logic [5:0]  fall;

    // Time base
    logic [7:0]  pre_q;
    logic        cnt_tick;
    logic [8:0]  slow_q;
    logic        slow_tick;
    logic [15:0] cnt_q;
    logic        upd_q;
    logic        ovf;
    logic        wr_cnt;

    // Compare and capture channels
    logic [15:0] cmp_q [1:4];
    logic [15:0] cap_q [1:3];
    logic [15:0] sh_q;
    logic [5:1]  hit;
    logic [5:1]  oc_q;
    logic [5:1]  oc_d;

    // Software registers
    logic [15:0] tctl_q;
    logic [15:0] oc1_q;
    logic [15:0] port_q;
    logic [3:0]  ivb_q;
    logic [6:0]  pa_q;
    logic        oe_q;

    // Accumulator
    logic [7:0]  acc_q;
    logic        acc_tick;
    logic        acc_inc;
    logic        sel;

    // Read path
    logic [15:0] rd_d;
    logic [15:0] rd_q;

    // Pin vector: captures, shared, accumulator, external clock
    assign raw = {ext_clk, acc_pin, ch45_sense, cap_pin};

    // Three-stage synchronisers, level taken when stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    s1_q[gi]   <= 1'b0;
                    s2_q[gi]   <= 1'b0;
                    s3_q[gi]   <= 1'b0;
                    lvl_q[gi]  <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        lvl_q[gi] <= s3_q[gi];
                    end
                    prev_q[gi] <= lvl_q[gi];
                end
            end
        end
    endgenerate

    // Edges of the filtered levels
    assign rise = lvl_q & ~prev_q;
    assign fall = ~lvl_q & prev_q;

    // Counter prescaler
    assign cnt_tick = (pre_q == 8'(`GTM_CNT_DIV - 1));

    always_ff @(posedge clk) begin
        if (sys_rst || cnt_tick) begin
            pre_q <= 8'h00;
        end else begin
            pre_q <= pre_q + 8'h01;
        end
    end

    // System clock over 512 for gated mode
    assign slow_tick = (slow_q == 9'(`GTM_DIV_SLOW - 1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slow_q <= 9'h000;
        end else begin
            slow_q <= slow_q + 9'h001;
        end
    end

    // Free-running counter, software may load it
    assign wr_cnt = wr_en && (addr == `GTM_A_CNT);
    assign ovf    = cnt_tick && !wr_cnt && (cnt_q == 16'hffff);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= `GTM_RST_ZERO;
        end else if (wr_cnt) begin
            cnt_q <= wr_data;
        end else if (cnt_tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Marks a fresh counter value for the compare stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            upd_q <= 1'b0;
        end else begin
            upd_q <= wr_cnt | cnt_tick;
        end
    end

    // Shared channel direction
    assign sel = pa_q[`GTM_B_SEL];

    // Compare matches, checked once per new counter value
    always_comb begin
        for (int k = 1; k <= 4; k++) begin
            hit[k] = upd_q && (cnt_q == cmp_q[k]);
        end
        hit[5] = upd_q && !sel && (cnt_q == sh_q);
    end

    // Pin actions; first-compare broadcast wins over own action
    always_comb begin
        oc_d = oc_q;
        for (int k = 2; k <= 5; k++) begin
            if (hit[k]) begin
                oc_d[k] = act_next(oc_q[k], tctl_q[2*k+5 -: 2]);
            end
        end
        if (hit[1]) begin
            for (int k = 1; k <= 5; k++) begin
                if (oc1_q[10+k]) begin
                    oc_d[k] = oc1_q[2+k];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oc_q <= 5'h00;
        end else begin
            oc_q <= oc_d;
        end
    end

    // Compare registers one to four
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int k = 1; k <= 4; k++) begin
                cmp_q[k] <= `GTM_RST_ONES;
            end
        end else if (wr_en) begin
            if (addr == `GTM_A_CMP1) begin
                cmp_q[1] <= wr_data;
            end else if (addr == `GTM_A_CMP2) begin
                cmp_q[2] <= wr_data;
            end else if (addr == `GTM_A_CMP3) begin
                cmp_q[3] <= wr_data;
            end else if (addr == `GTM_A_CMP4) begin
                cmp_q[4] <= wr_data;
            end
        end
    end

    // Capture registers one to three
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int c = 1; c <= 3; c++) begin
                cap_q[c] <= `GTM_RST_ONES;
            end
        end else begin
            for (int c = 1; c <= 3; c++) begin
                if (cap_fire(tctl_q[2*c-1 -: 2], rise[c-1], fall[c-1])) begin
                    cap_q[c] <= cnt_q;
                end
            end
        end
    end

    // Shared register; a capture beats a write in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_q <= `GTM_RST_ONES;
        end else if (sel && cap_fire(tctl_q[7:6], rise[3], fall[3])) begin
            sh_q <= cnt_q;
        end else if (wr_en && (addr == `GTM_A_SHARED)) begin
            sh_q <= wr_data;
        end
    end

    // Compare action and capture edge control
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tctl_q <= `GTM_RST_ZERO;
        end else if (wr_en && (addr == `GTM_A_TCTL)) begin
            tctl_q <= wr_data;
        end
    end

    // First-compare mask and data, reserved bits kept zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oc1_q <= `GTM_RST_ZERO;
        end else if (wr_en && (addr == `GTM_A_OC1)) begin
            oc1_q <= wr_data & `GTM_OC1_MASK;
        end
    end

    // Port direction and data, storage only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_q <= `GTM_RST_ZERO;
        end else if (wr_en && (addr == `GTM_A_PORT)) begin
            port_q <= wr_data;
        end
    end

    // Vector base nibble
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ivb_q <= 4'h0;
        end else if (wr_en && (addr == `GTM_A_ICR)) begin
            ivb_q <= wr_data[7:4];
        end
    end

    // Gated-mode clock source selection
    always_comb begin
        case (gtm_clk_sel_t'(pa_q[1:0]))
            GTM_CLK_DIV512: acc_tick = slow_tick;
            GTM_CLK_COUNT:  acc_tick = cnt_tick;
            GTM_CLK_OVF:    acc_tick = ovf;
            default:        acc_tick = rise[5];
        endcase
    end

    // Accumulator increment decision
    always_comb begin
        if (!pa_q[`GTM_B_EN]) begin
            acc_inc = 1'b0;
        end else if (!pa_q[`GTM_B_GATED]) begin
            acc_inc = pa_q[`GTM_B_EDGE] ? rise[4] : fall[4];
        end else begin
            acc_inc = acc_tick && (pa_q[`GTM_B_EDGE] ^ lvl_q[4]);
        end
    end

    // Accumulator control; status bits 15 and 11 never stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pa_q <= 7'h00;
            oe_q <= 1'b1;
        end else if (wr_en && (addr == `GTM_A_ACC)) begin
            pa_q <= wr_data[14:8] & 7'(`GTM_ACC_WMASK);
            oe_q <= ~wr_data[8 + `GTM_B_SEL];
        end
    end

    // Accumulator count; a write beats an increment
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_q <= 8'h00;
        end else if (wr_en && (addr == `GTM_A_ACC)) begin
            acc_q <= wr_data[7:0];
        end else if (acc_inc) begin
            acc_q <= acc_q + 8'h01;
        end
    end

    // Read data selection
    always_comb begin
        if (addr == `GTM_A_ICR) begin
            rd_d = {8'h00, ivb_q, 4'h0};
        end else if (addr == `GTM_A_PORT) begin
            rd_d = port_q;
        end else if (addr == `GTM_A_OC1) begin
            rd_d = oc1_q;
        end else if (addr == `GTM_A_CNT) begin
            rd_d = cnt_q;
        end else if (addr == `GTM_A_ACC) begin
            rd_d = {lvl_q[4], pa_q[6:4], lvl_q[5], pa_q[2:0],
                    acc_q};
        end else if (addr == `GTM_A_CAP1) begin
            rd_d = cap_q[1];
        end else if (addr == `GTM_A_CAP2) begin
            rd_d = cap_q[2];
        end else if (addr == `GTM_A_CAP3) begin
            rd_d = cap_q[3];
        end else if (addr == `GTM_A_CMP1) begin
            rd_d = cmp_q[1];
        end else if (addr == `GTM_A_CMP2) begin
            rd_d = cmp_q[2];
        end else if (addr == `GTM_A_CMP3) begin
            rd_d = cmp_q[3];
        end else if (addr == `GTM_A_CMP4) begin
            rd_d = cmp_q[4];
        end else if (addr == `GTM_A_SHARED) begin
            rd_d = sh_q;
        end else if (addr == `GTM_A_TCTL) begin
            rd_d = tctl_q;
        end else begin
            rd_d = 16'h0000;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst || !rd_en) begin
            rd_q <= 16'h0000;
        end else begin
            rd_q <= rd_d;
        end
    end

    // Outputs straight from flip-flops
    assign rd_data  = rd_q;
    assign cmp_pin  = oc_q[4:1];
    assign ch45_drive = oc_q[5];
    assign ch45_oe    = oe_q;
    assign vec_base = ivb_q;

endmodule

//--- dv/gtm_timer_asserts.sv
// Bound checker for the timer port behaviour
`timescale 1ns/1ps
`include "gtm_cfg.svh"
module gtm_timer_asserts (
    input wire logic        clk,      // Clock
    input wire logic        sys_rst,  // Reset
    input wire logic [7:0]  addr,     // Offset
    input wire logic [15:0] wr_data,  // Write data
    input wire logic        wr_en,    // Write strobe
    input wire logic        rd_en,    // Read strobe
    input wire logic [15:0] rd_data,  // Read data
    input wire logic        ch45_oe,  // Shared enable
    input wire logic [4:1]  cmp_pin,  // Compare pins
    input wire logic [3:0]  vec_base  // Vector nibble
);
    logic [15:0] ctl_q; // Control shadow
    logic [15:0] act_q; // Action shadow
    logic [15:0] msk_q; // Broadcast shadow
    logic        off;   // No action armed for compare pins one to four
    assign off = act_q[13:8] == 6'h00 && msk_q[14:11] == 4'h0;
    // Shadows follow software writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_q <= 16'h0000;
            act_q <= 16'h0000;
            msk_q <= 16'h0000;
        end else if (wr_en) begin
            if (addr == `GTM_A_ACC) ctl_q <= wr_data;
            if (addr == `GTM_A_TCTL) act_q <= wr_data;
            if (addr == `GTM_A_OC1) msk_q <= wr_data;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd(logic [7:0] a);
        rd_en && addr == a;
    endsequence
    property p_rd_idle;
        !rd_en |=> rd_data == 16'h0000;
    endproperty
    property p_unmap;
        s_rd(8'h00) |=> rd_data == 16'h0000;
    endproperty
    property p_oc1_rsv;
        s_rd(`GTM_A_OC1) |=> (rd_data & 16'h0707) == 16'h0000;
    endproperty
    property p_acc_ctl;
        s_rd(`GTM_A_ACC) |=> (rd_data & 16'h7700) == ($past(ctl_q) & 16'h7700);
    endproperty
    property p_oe;
        ch45_oe == !ctl_q[10];
    endproperty
    property p_vec;
        wr_en && addr == `GTM_A_ICR
            |=> 16'({vec_base, 4'h0}) == ($past(wr_data) & `GTM_ICR_MASK);
    endproperty
    property p_off;
        off && $past(off) && $past(off, 2) |-> $stable(cmp_pin);
    endproperty
    property p_rst;
        $fell(sys_rst) |-> cmp_pin == 4'h0 && ch45_oe && vec_base == 4'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    a_unmap: assert property (p_unmap)
        else $error("unmapped read nonzero");
    a_oc1_rsv: assert property (p_oc1_rsv)
        else $error("reserved bits set");
    a_acc_ctl: assert property (p_acc_ctl)
        else $error("control readback");
    a_oe: assert property (p_oe)
        else $error("shared enable wrong");
    a_vec: assert property (p_vec)
        else $error("vector nibble wrong");
    a_off: assert property (p_off)
        else $error("idle compare pin moved");
    a_rst: assert property (p_rst)
        else $error("pins after reset");
endmodule
bind gtm_timer gtm_timer_asserts gtm_timer_asserts_inst (.clk, .sys_rst,
    .addr, .wr_data, .wr_en, .rd_en, .rd_data, .ch45_oe, .cmp_pin, .vec_base);

//--- dv/gtm_pins_model.sv
// Far-side pin model for capture, shared and accumulator pins
`timescale 1ns/1ps
module gtm_pins_model (
    input  wire logic       clk,      // Clock
    input  wire logic [5:0] lvl,      // Requested levels
    input  wire logic       ch45_drive, // Device shared level
    input  wire logic       ch45_oe,    // Device drives shared
    output logic      [3:1] cap_pin,    // Capture pins
    output logic            ch45_sense, // Shared wire level
    output logic            acc_pin,    // Accumulator pin
    output logic            ext_clk   // External clock pin
);
    logic [5:0] pin_q = 6'h00; // Pin levels
    logic       own45;         // Model side of shared pin
    // Pins move just after the edge
    always @(posedge clk) begin
        pin_q <= lvl;
    end
    assign {ext_clk, acc_pin, own45, cap_pin} = pin_q;
    // Shared wire resolved from the device enable
    assign ch45_sense = ch45_oe ? ch45_drive : own45;
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the timer
`timescale 1ns/1ps
`include "gtm_cfg.svh"
module tb_top;
    logic        clk = 1'b0;      // Clock
    logic        sys_rst = 1'b1;  // Reset
    logic        wr_en = 1'b0;    // Write strobe
    logic        rd_en = 1'b0;    // Read strobe
    logic [7:0]  addr = 8'h00;    // Offset
    logic [15:0] wr_data = 16'h0; // Write data
    logic [15:0] v;               // Last read
    logic [5:0]  lvl = 6'h00;     // Pin levels
    wire  [15:0] rd_data;
    wire  [4:1]  cmp_pin;
    wire  [3:1]  cap_pin;
    wire  [3:0]  vec_base;
    wire         ch45_sense, ch45_drive, ch45_oe, acc_pin, ext_clk;
    int          miscompares = 0;
    int          cmp_count = 0;
    gtm_timer gtm_timer_inst (.clk, .sys_rst, .addr, .wr_data, .wr_en,
        .rd_en, .rd_data, .cap_pin, .ch45_sense, .ch45_drive, .ch45_oe,
        .acc_pin, .ext_clk, .cmp_pin, .vec_base);
    gtm_pins_model gtm_pins_model_inst (.clk, .lvl, .ch45_drive, .ch45_oe,
        .cap_pin, .ch45_sense, .acc_pin, .ext_clk);
    // Clock
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
        @(posedge clk);
    endtask
    task automatic chk(input string n, input logic [15:0] s, e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] m, e);
        rd(a);
        chk($sformatf("reg %h", a), v & m, e);
    endtask
    task automatic inr(input logic [7:0] a, input logic [15:0] m, lo, hi);
        rd(a);
        chk($sformatf("range %h", a), 16'((v & m) >= lo && (v & m) <= hi), 1);
    endtask
    task automatic pulse(input int b, n);
        repeat (n) begin
            lvl[b] <= 1'b1;
            tick(8);
            lvl[b] <= 1'b0;
            tick(8);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        tick(20000);
        miscompares++;
        conclude();
    end
    // Main sequence
    initial begin
        tick(5);
        sys_rst <= 1'b0;
        tick(1);
        for (int a = 14; a <= 28; a += 2) begin
            rc(8'(a), 16'hffff, 16'hffff);
        end
        rc(`GTM_A_TCTL, 16'hffff, 16'h0000);
        chk("oe", 16'(ch45_oe), 16'h1);
        wr(`GTM_A_ICR, 16'h5a5a);
        rc(`GTM_A_ICR, 16'hffff, 16'h0050);
        chk("vec", 16'(vec_base), 16'h5);
        wr(`GTM_A_OC1, 16'hffff);
        rc(`GTM_A_OC1, 16'hffff, 16'hf8f8);
        wr(`GTM_A_CAP1, 16'h1234);
        rc(`GTM_A_CAP1, 16'hffff, 16'hffff);
        wr(`GTM_A_CMP3, 16'h1234);
        rc(`GTM_A_CMP3, 16'hffff, 16'h1234);
        rc(8'h00, 16'hffff, 16'h0000);
        wr(`GTM_A_CNT, 16'h3000);
        inr(`GTM_A_CNT, 16'hffff, 16'h3000, 16'h3002);
        // Compare actions high, low, toggle, none
        wr(`GTM_A_OC1, 16'h0000);
        wr(`GTM_A_CMP2, 16'h0102);
        for (int i = 0; i < 4; i++) begin
            wr(`GTM_A_TCTL, 16'(3 - i) << 8);
            wr(`GTM_A_CNT, 16'h0100);
            tick(20);
            chk("cmp2", 16'(cmp_pin[2]), 16'(4'hd >> i) & 16'h1);
        end
        // Broadcast from the first compare
        wr(`GTM_A_OC1, 16'hf8a8);
        wr(`GTM_A_CMP1, 16'h0200);
        wr(`GTM_A_CNT, 16'h01fe);
        tick(20);
        chk("bcast", 16'({ch45_drive, cmp_pin}), 16'h15);
        wr(`GTM_A_OC1, 16'h2800);
        wr(`GTM_A_CNT, 16'h01fe);
        tick(20);
        chk("bmask", 16'({ch45_drive, cmp_pin}), 16'h10);
        // Compare five drives the shared pin low
        wr(`GTM_A_SHARED, 16'h0302);
        wr(`GTM_A_TCTL, 16'h8000);
        wr(`GTM_A_CNT, 16'h0300);
        tick(20);
        chk("cmp5", 16'(ch45_drive), 16'h0);
        // Captures: rise, fall, any, shared rise
        wr(`GTM_A_OC1, 16'h0000);
        wr(`GTM_A_ACC, 16'h0400);
        chk("oe", 16'(ch45_oe), 16'h0);
        wr(`GTM_A_TCTL, 16'h0079);
        wr(`GTM_A_CNT, 16'h1000);
        lvl[3:0] <= 4'hf;
        tick(10);
        inr(`GTM_A_CAP1, 16'hffff, 16'h1000, 16'h1004);
        rc(`GTM_A_CAP2, 16'hffff, 16'hffff);
        inr(`GTM_A_CAP3, 16'hffff, 16'h1000, 16'h1004);
        inr(`GTM_A_SHARED, 16'hffff, 16'h1000, 16'h1004);
        wr(`GTM_A_CNT, 16'h2000);
        lvl[3:0] <= 4'h0;
        tick(10);
        inr(`GTM_A_CAP1, 16'hffff, 16'h1000, 16'h1004);
        inr(`GTM_A_CAP2, 16'hffff, 16'h2000, 16'h2004);
        inr(`GTM_A_CAP3, 16'hffff, 16'h2000, 16'h2004);
        // Event counting, wrap, disable
        wr(`GTM_A_ACC, 16'h44fe);
        pulse(4, 3);
        rc(`GTM_A_ACC, 16'h00ff, 16'h0001);
        wr(`GTM_A_ACC, 16'h0400);
        pulse(4, 2);
        rc(`GTM_A_ACC, 16'h00ff, 16'h0000);
        wr(`GTM_A_ACC, 16'h5400);
        pulse(4, 2);
        rc(`GTM_A_ACC, 16'h00ff, 16'h0002);
        // Pin level status bits
        lvl[5:4] <= 2'b01;
        tick(8);
        rc(`GTM_A_ACC, 16'h8800, 16'h8000);
        lvl[5:4] <= 2'b10;
        wr(`GTM_A_ACC, 16'h8400);
        tick(8);
        rc(`GTM_A_ACC, 16'h8800, 16'h0800);
        // Gated mode, external clock, low inhibits
        lvl[5:4] <= 2'b01;
        tick(8);
        wr(`GTM_A_ACC, 16'h6700);
        pulse(5, 4);
        lvl[4] <= 1'b0;
        tick(8);
        pulse(5, 3);
        rc(`GTM_A_ACC, 16'h00ff, 16'h0004);
        // Gated mode, high inhibits
        wr(`GTM_A_ACC, 16'h7700);
        pulse(5, 2);
        lvl[4] <= 1'b1;
        tick(8);
        pulse(5, 2);
        rc(`GTM_A_ACC, 16'h00ff, 16'h0002);
        // Gated mode, counter tick, overflow, slow clock
        wr(`GTM_A_ACC, 16'h6500);
        tick(40);
        inr(`GTM_A_ACC, 16'h00ff, 16'h0009, 16'h000d);
        wr(`GTM_A_CNT, 16'hfffe);
        wr(`GTM_A_ACC, 16'h6600);
        tick(20);
        rc(`GTM_A_ACC, 16'h00ff, 16'h0001);
        wr(`GTM_A_ACC, 16'h6400);
        tick(1100);
        inr(`GTM_A_ACC, 16'h00ff, 16'h0002, 16'h0003);
        conclude();
    end
endmodule
